// *** hdl/fscr_pkg.sv ***
package fscr_pkg;

   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [7:0] FSCR_OFS_CTX   = 8'h00;
   localparam logic [7:0] FSCR_OFS_FRAME = 8'h04;
   localparam logic [7:0] FSCR_OFS_STAT  = 8'h08;
   localparam logic [7:0] FSCR_OFS_DFLT  = 8'h0c;
   localparam logic [7:0] FSCR_OFS_IRQS  = 8'h10;
   localparam logic [7:0] FSCR_OFS_IRQM  = 8'h14;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int FSCR_CTX_EN_BIT   = 31;
   localparam int FSCR_CTX_PEND_BIT = 0;
   localparam int FSCR_FRAME_LSB    = 3;
   localparam int FSCR_N_BIT        = 31;
   localparam int FSCR_Z_BIT        = 30;
   localparam int FSCR_C_BIT        = 29;
   localparam int FSCR_V_BIT        = 28;
   localparam int FSCR_AHP_BIT      = 26;
   localparam int FSCR_DN_BIT       = 25;
   localparam int FSCR_FZ_BIT       = 24;
   localparam int FSCR_RM_MSB       = 23;
   localparam int FSCR_RM_LSB       = 22;
   localparam int FSCR_IDC_BIT      = 7;
   localparam int FSCR_IXC_BIT      = 4;
   localparam int FSCR_UFC_BIT      = 3;
   localparam int FSCR_OFC_BIT      = 2;
   localparam int FSCR_DZC_BIT      = 1;
   localparam int FSCR_IOC_BIT      = 0;
   localparam int FSCR_IRQ_W        = 7;
   localparam int FSCR_IRQ_LAZY_BIT = 6;

   // ************************************************************
   // Reset values and responses
   // ************************************************************
   localparam logic [31:0] FSCR_RST_WORD  = 32'h0000_0000;
   localparam logic        FSCR_RST_LAZY  = 1'b1;
   localparam logic [1:0]  FSCR_RESP_OK   = 2'h0;
   localparam logic [1:0]  FSCR_RESP_ERR  = 2'h2;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      FSCR_RND_NEAREST = 2'h0,
      FSCR_RND_PLUS    = 2'h1,
      FSCR_RND_MINUS   = 2'h2,
      FSCR_RND_ZERO    = 2'h3
   } fscr_rnd_t;

   typedef struct packed {
      logic      alt_half_precision_select;
      logic      default_nan_select;
      logic      flush_to_zero_select;
      fscr_rnd_t rounding_select;
   } fscr_mode_t;

   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } fscr_nzcv_t;

   typedef struct packed {
      logic input_denormal;
      logic inexact;
      logic underflow;
      logic overflow;
      logic divide_by_zero;
      logic invalid_op;
   } fscr_exc_t;

endpackage

// *** hdl/fscr_sticky.sv ***
`timescale 1ns/1ps
module fscr_sticky #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             reset,
   // Set and clear masks.
   input  wire logic [WIDTH-1:0] set,
   input  wire logic [WIDTH-1:0] clr,
   // Stored bits.
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] q_q;
   logic [WIDTH-1:0] q_d;

   // A set arriving with a clear sets the bit.
   assign q_d = (q_q & ~clr) | set;
   assign q   = q_q;

   always_ff @(posedge clk)
   begin
      if (reset)
         q_q <= '0;
      else
         q_q <= q_d;
   end

   set_wins_a: assert property (@(posedge clk) disable iff (reset)
      set != '0 |=> (q_q & $past(set)) == $past(set))
      else $error("sticky set lost");

endmodule

// *** hdl/fscr_regs.sv ***
`timescale 1ns/1ps
// Behaviour
// RULE1: The pending flag goes to one when a frame is reserved and returns to zero once saved.
// RULE2: The frame address register holds the location of the reserved, still empty area.
// RULE3: Every comparison result loads the N, Z, C and V flags of the status word.
// RULE4: The half-precision select bit picks the standard format at zero, the alternative at one.
// RULE5: The default-NaN bit at one forces the default NaN, at zero NaNs pass through.
// RULE6: The flush-to-zero bit at zero gives full compliance, at one flush-to-zero mode.
// RULE7: The rounding field decodes 00 nearest, 01 plus, 10 minus and 11 toward zero.
// RULE8: Six sticky exception bits are set by their events and held until written with zero.
// RULE9: The default register holds half-precision, default-NaN and flush defaults at 26, 25, 24.
// RULE10: The default register holds the default rounding field at bits 23 and 22.
// RULE11: Software grants coprocessor access before any floating-point instruction.
// RULE12: A frame is reserved lazily, and the pending flag rises, only while lazy save is enabled.
// RULE13: A new context loads the mode fields of the status word from the default register.
// RULE14: Reserved bits read as zero and ignore writes.
module fscr_regs
(
   // Clock and reset.
   input  wire logic               clk,
   input  wire logic               reset,
   // AXI4-Lite write address, data and response.
   input  wire logic [31:0]        s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [31:0]        s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // Datapath events.
   input  wire logic               frame_reserve,
   input  wire logic [31:0]        frame_addr_in,
   input  wire logic               frame_saved,
   input  wire logic               cmp_valid,
   input  wire fscr_pkg::fscr_nzcv_t cmp_flags,
   input  wire logic               exc_valid,
   input  wire fscr_pkg::fscr_exc_t  exc_flags,
   input  wire logic               new_context,
   // Datapath controls.
   output fscr_pkg::fscr_mode_t    fp_mode,
   output logic                    lazy_save_enable,
   output logic                    lazy_save_pending,
   output logic [31:0]             fp_frame_address,
   // Interrupt.
   output logic                    irq
);
   import fscr_pkg::*;

   // ************************************************************
   // Bus slave
   // ************************************************************
   logic        aw_q;
   logic        w_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [1:0]  rresp_q;
   logic [31:0] rdata_q;
   logic        do_write;
   logic        do_read;
   logic [31:0] bmask;
   logic [31:0] rd_word;
   logic        rd_hit;
   logic        wr_hit;

   assign s_axi_awready = !aw_q && !bvalid_q;
   assign s_axi_wready  = !w_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign do_write      = aw_q && w_q && !bvalid_q;
   assign do_read       = s_axi_arvalid && !rvalid_q;
   assign bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         aw_q     <= 1'b0;
         awaddr_q <= 8'h00;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_q     <= 1'b1;
         awaddr_q <= s_axi_awaddr[7:0];
      end
      else if (do_write)
         aw_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         w_q     <= 1'b0;
         wdata_q <= FSCR_RST_WORD;
         wstrb_q <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_q     <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end
      else if (do_write)
         w_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= FSCR_RESP_OK;
      end
      else if (do_write)
      begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit ? FSCR_RESP_OK : FSCR_RESP_ERR;
      end
      else if (s_axi_bready)
         bvalid_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rvalid_q <= 1'b0;
         rresp_q  <= FSCR_RESP_OK;
         rdata_q  <= FSCR_RST_WORD;
      end
      else if (do_read)
      begin
         rvalid_q <= 1'b1;
         rresp_q  <= rd_hit ? FSCR_RESP_OK : FSCR_RESP_ERR;
         rdata_q  <= rd_word;
      end
      else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end

   // ************************************************************
   // Register storage
   // ************************************************************
   logic        lazy_en_q;
   logic        pend_q;
   logic [28:0] frame_q;
   fscr_nzcv_t  nzcv_q;
   fscr_mode_t  mode_q;
   fscr_mode_t  dflt_q;
   logic [5:0]  exc_q;
   logic [FSCR_IRQ_W-1:0] irqs_q;
   logic [FSCR_IRQ_W-1:0] irqm_q;
   logic [31:0] stat_word;
   logic [31:0] dflt_word;
   logic [31:0] wmerge;
   logic        we_ctx;
   logic        we_frame;
   logic        we_stat;
   logic        we_dflt;
   logic        we_irqs;
   logic        we_irqm;
   logic        reserve_ok;
   logic [5:0]  exc_set;
   logic [5:0]  exc_clr;
   logic [5:0]  exc_wd;
   logic [5:0]  exc_wm;
   logic [FSCR_IRQ_W-1:0] irq_set;
   logic [FSCR_IRQ_W-1:0] irq_clr;

   assign we_ctx   = do_write && (awaddr_q == FSCR_OFS_CTX);
   assign we_frame = do_write && (awaddr_q == FSCR_OFS_FRAME);
   assign we_stat  = do_write && (awaddr_q == FSCR_OFS_STAT);
   assign we_dflt  = do_write && (awaddr_q == FSCR_OFS_DFLT);
   assign we_irqs  = do_write && (awaddr_q == FSCR_OFS_IRQS);
   assign we_irqm  = do_write && (awaddr_q == FSCR_OFS_IRQM);
   assign wr_hit   = we_ctx || we_frame || we_stat || we_dflt || we_irqs || we_irqm;
   always_comb wmerge = (rd_mux(awaddr_q) & ~bmask) | (wdata_q & bmask);
   assign reserve_ok = frame_reserve && lazy_en_q; // RULE12

   always_ff @(posedge clk)
   begin
      if (reset)
         lazy_en_q <= FSCR_RST_LAZY;
      else if (we_ctx)
         lazy_en_q <= wmerge[FSCR_CTX_EN_BIT];
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         pend_q <= 1'b0;
      else if (reserve_ok)
         pend_q <= 1'b1; // RULE1 RULE12
      else if (frame_saved)
         pend_q <= 1'b0; // RULE1
   end

   // The datapath reservation takes priority over a software write.
   always_ff @(posedge clk)
   begin
      if (reset)
         frame_q <= FSCR_RST_WORD[31:3];
      else if (reserve_ok)
         frame_q <= frame_addr_in[31:FSCR_FRAME_LSB]; // RULE2
      else if (we_frame)
         frame_q <= wmerge[31:FSCR_FRAME_LSB]; // RULE2 RULE14
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         nzcv_q <= fscr_nzcv_t'(FSCR_RST_WORD[3:0]);
      else if (cmp_valid)
         nzcv_q <= cmp_flags; // RULE3
      else if (we_stat)
         nzcv_q <= wmerge[FSCR_N_BIT:FSCR_V_BIT];
   end

   // A new context overrides a software write in the same cycle.
   always_ff @(posedge clk)
   begin
      if (reset)
         mode_q <= fscr_mode_t'(FSCR_RST_WORD[4:0]);
      else if (new_context)
         mode_q <= dflt_q; // RULE13
      else if (we_stat)
         mode_q <= wmerge[FSCR_AHP_BIT:FSCR_RM_LSB]; // RULE4 RULE5 RULE6 RULE7
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         dflt_q <= fscr_mode_t'(FSCR_RST_WORD[4:0]);
      else if (we_dflt)
         dflt_q <= wmerge[FSCR_AHP_BIT:FSCR_RM_LSB]; // RULE9 RULE10
   end

   // ************************************************************
   // Sticky exception bits
   // ************************************************************
   assign exc_wd = {wmerge[FSCR_IDC_BIT], wmerge[FSCR_IXC_BIT:FSCR_IOC_BIT]};
   assign exc_wm = we_stat ? 6'h3f : 6'h00;
   assign exc_set = (exc_valid ? exc_flags : 6'h00) | (exc_wm & exc_wd); // RULE8
   assign exc_clr = exc_wm & ~exc_wd; // RULE8

   fscr_sticky #(
      .WIDTH (6)
   ) u_exc (
      .clk   (clk),
      .reset (reset),
      .set   (exc_set),
      .clr   (exc_clr),
      .q     (exc_q)
   );

   // ************************************************************
   // Interrupt status and mask
   // ************************************************************
   assign irq_set = {reserve_ok, (exc_valid ? exc_flags : 6'h00)};
   assign irq_clr = we_irqs ? (wdata_q[FSCR_IRQ_W-1:0] & bmask[FSCR_IRQ_W-1:0]) : '0;

   fscr_sticky #(
      .WIDTH (FSCR_IRQ_W)
   ) u_irq (
      .clk   (clk),
      .reset (reset),
      .set   (irq_set),
      .clr   (irq_clr),
      .q     (irqs_q)
   );

   always_ff @(posedge clk)
   begin
      if (reset)
         irqm_q <= FSCR_RST_WORD[FSCR_IRQ_W-1:0];
      else if (we_irqm)
         irqm_q <= wmerge[FSCR_IRQ_W-1:0];
   end

   assign irq = |(irqs_q & irqm_q);

   // ************************************************************
   // Read mux
   // ************************************************************
   assign stat_word = {nzcv_q, 1'b0, mode_q, 14'h0000, exc_q[5], 2'h0, exc_q[4:0]}; // RULE14
   assign dflt_word = {5'h00, dflt_q, 22'h000000}; // RULE9 RULE10 RULE14

   function automatic logic [31:0] rd_mux(input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (a)
         FSCR_OFS_CTX:   v = {lazy_en_q, 30'h00000000, pend_q};
         FSCR_OFS_FRAME: v = {frame_q, 3'h0};
         FSCR_OFS_STAT:  v = stat_word;
         FSCR_OFS_DFLT:  v = dflt_word;
         FSCR_OFS_IRQS:  v = {25'h0000000, irqs_q};
         FSCR_OFS_IRQM:  v = {25'h0000000, irqm_q};
         default:        v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // Processes rather than assigns, so that the register reads inside rd_mux wake them.
   always_comb rd_word = rd_mux(s_axi_araddr[7:0]);
   assign rd_hit  = (s_axi_araddr[7:0] <= FSCR_OFS_IRQM) && (s_axi_araddr[1:0] == 2'h0);

   // ************************************************************
   // Outputs
   // ************************************************************
   assign fp_mode           = mode_q; // RULE4 RULE5 RULE6 RULE7
   assign lazy_save_enable  = lazy_en_q;
   assign lazy_save_pending = pend_q;
   assign fp_frame_address  = {frame_q, 3'h0};

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence reserve_s;
      frame_reserve && lazy_en_q;
   endsequence

   sequence write_pair_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   pend_set_a: assert property (reserve_s |=> pend_q) // RULE1
      else $error("pending flag did not rise");
   pend_gate_a: assert property ($rose(pend_q) |-> $past(frame_reserve && lazy_en_q)) // RULE12
      else $error("pending rose without enabled reservation");
   pend_clr_a: assert property (frame_saved && !frame_reserve |=> !pend_q) // RULE1
      else $error("pending flag not cleared after save");
   frame_load_a: assert property (reserve_s |=>
      fp_frame_address == {$past(frame_addr_in[31:3]), 3'h0}) // RULE2
      else $error("frame address not captured");
   nzcv_load_a: assert property (cmp_valid |=> nzcv_q == $past(cmp_flags)) // RULE3
      else $error("condition flags not updated");
   exc_hold_a: assert property ($fell(exc_q[0]) |-> $past(we_stat && !wmerge[0])) // RULE8
      else $error("sticky exception cleared without write of zero");
   newctx_a: assert property (new_context |=> fp_mode == $past(dflt_q)) // RULE13
      else $error("new context did not take defaults");
   resv_zero_a: assert property (stat_word[27] == 1'b0 && dflt_word[21:0] == 22'h000000
      && fp_frame_address[2:0] == 3'h0) // RULE14
      else $error("reserved bits not zero");
   bresp_time_a: assert property (write_pair_s ##1 !bvalid_q |=> bvalid_q)
      else $error("write response late");
   irq_lazy_a: assert property (reserve_s |=> irqs_q[FSCR_IRQ_LAZY_BIT])
      else $error("lazy reservation did not raise its interrupt status");
endmodule

// *** bench/fscr_core_model.sv ***
`timescale 1ns/1ps
module fscr_core_model
(
   // Clock and reset.
   input  wire logic           clk,
   input  wire logic           reset,
   // Commands from the bench.
   input  wire logic           granted,
   input  wire logic           go,
   input  wire logic [2:0]     op,
   input  wire logic [31:0]    arg,
   // Datapath events.
   output logic                frame_reserve,
   output logic [31:0]         frame_addr_in,
   output logic                frame_saved,
   output logic                cmp_valid,
   output fscr_pkg::fscr_nzcv_t cmp_flags,
   output logic                exc_valid,
   output fscr_pkg::fscr_exc_t  exc_flags,
   output logic                new_context
);
   import fscr_pkg::*;

   // ************************************************************
   // Event pulses
   // ************************************************************
   // Payloads flip every idle cycle so a stale value is never reused.
   always_ff @(posedge clk)
   begin
      frame_reserve <= 1'b0;
      frame_saved   <= 1'b0;
      cmp_valid     <= 1'b0;
      exc_valid     <= 1'b0;
      new_context   <= 1'b0;
      frame_addr_in <= ~frame_addr_in;
      cmp_flags     <= ~cmp_flags;
      exc_flags     <= ~exc_flags;
      if (reset)
      begin
         frame_addr_in <= 32'h0;
         cmp_flags     <= 4'h0;
         exc_flags     <= 6'h0;
      end
      else if (go && granted)
      begin
         case (op)
            3'h0:
            begin
               frame_reserve <= 1'b1;
               frame_addr_in <= arg;
            end
            3'h1: frame_saved <= 1'b1;
            3'h2:
            begin
               cmp_valid <= 1'b1;
               cmp_flags <= arg[3:0];
            end
            3'h3:
            begin
               exc_valid <= 1'b1;
               exc_flags <= arg[5:0];
            end
            default: new_context <= 1'b1;
         endcase
      end
   end
endmodule

// *** bench/tb_fscr_regs.sv ***
`timescale 1ns/1ps
module tb_fscr_regs;
   import fscr_pkg::*;

   logic clk, reset, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [31:0] awaddr, wdata, araddr, rdata, arg, faddr, frame;
   logic [1:0] bresp, rresp;
   logic [2:0] op;
   logic [3:0] wstrb;
   logic granted, go, fres, fsav, cval, eval, nctx, lse, lsp;
   fscr_nzcv_t cfl;
   fscr_exc_t efl;
   fscr_mode_t mode;
   int error_cnt, n_tests;

   always #10 clk = ~clk;

   fscr_regs i_fscr_regs (.clk(clk), .reset(reset),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frame_reserve(fres),
      .frame_addr_in(faddr), .frame_saved(fsav), .cmp_valid(cval),
      .cmp_flags(cfl), .exc_valid(eval), .exc_flags(efl), .new_context(nctx),
      .fp_mode(mode), .lazy_save_enable(lse), .lazy_save_pending(lsp),
      .fp_frame_address(frame), .irq(irq));

   fscr_core_model i_fscr_core_model (.clk(clk), .reset(reset),
      .granted(granted), .go(go), .op(op), .arg(arg), .frame_reserve(fres),
      .frame_addr_in(faddr), .frame_saved(fsav), .cmp_valid(cval),
      .cmp_flags(cfl), .exc_valid(eval), .exc_flags(efl), .new_context(nctx));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic tout();
      error_cnt++;
      $display("CHECK FAILED at %0t: no answer on the bus", $time);
      end_sim();
   endtask

   task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic [1:0] r;
      n = 0;
      r = 2'bx;
      @(posedge clk);
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bready && bvalid)
         begin
            r = bresp;
            bready <= 1'b0;
         end
      end while ((awvalid || wvalid || bready) && n < 100);
      if (n >= 100) tout();
      chk({30'h0, r}, {30'h0, er});
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      logic [31:0] d;
      logic [1:0] r;
      n = 0;
      r = 2'bx;
      d = 'x;
      @(posedge clk);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rready && rvalid)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
      end while ((arvalid || rready) && n < 100);
      if (n >= 100) tout();
      chk(d, e);
      chk({30'h0, r}, {30'h0, er});
   endtask

   task automatic ev(input logic [2:0] o, input logic [31:0] d);
      @(posedge clk);
      go <= 1'b1;
      op <= o;
      arg <= d;
      @(posedge clk);
      go <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      rdc(FSCR_OFS_CTX, 32'h8000_0000, FSCR_RESP_OK);
      for (int i = 1; i < 6; i++)
         rdc(8'(i * 4), 32'h0, FSCR_RESP_OK);
      chk({31'h0, irq}, 32'h0);
      $display("reset values done");
   endtask

   task automatic t_modes();
      logic [31:0] v;
      wrc(FSCR_OFS_DFLT, 32'hffff_ffff, FSCR_RESP_OK);
      rdc(FSCR_OFS_DFLT, 32'h07c0_0000, FSCR_RESP_OK);
      ev(3'h4, 32'h0);
      chk({27'h0, mode}, 32'h1f);
      rdc(FSCR_OFS_STAT, 32'h07c0_0000, FSCR_RESP_OK);
      for (int r = 0; r < 4; r++)
      begin
         v = {5'h0, r[0], r[1], ~r[0], r[1:0], 22'h0};
         wrc(FSCR_OFS_STAT, v | 32'h0800_ff60, FSCR_RESP_OK);
         rdc(FSCR_OFS_STAT, v, FSCR_RESP_OK);
         chk({27'h0, mode}, {27'h0, r[0], r[1], ~r[0], r[1:0]});
      end
      $display("mode fields done");
   endtask

   task automatic t_cmp();
      wrc(FSCR_OFS_STAT, 32'h0, FSCR_RESP_OK);
      ev(3'h2, 32'ha);
      rdc(FSCR_OFS_STAT, 32'ha000_0000, FSCR_RESP_OK);
      ev(3'h2, 32'h5);
      rdc(FSCR_OFS_STAT, 32'h5000_0000, FSCR_RESP_OK);
      $display("compare flags done");
   endtask

   task automatic t_exc();
      wrc(FSCR_OFS_STAT, 32'h0, FSCR_RESP_OK);
      wrc(FSCR_OFS_IRQM, 32'h3f, FSCR_RESP_OK);
      ev(3'h3, 32'h21);
      ev(3'h3, 32'h0);
      rdc(FSCR_OFS_STAT, 32'h81, FSCR_RESP_OK);
      chk({31'h0, irq}, 32'h1);
      ev(3'h3, 32'h1e);
      rdc(FSCR_OFS_STAT, 32'h9f, FSCR_RESP_OK);
      wrc(FSCR_OFS_STAT, 32'h0, FSCR_RESP_OK);
      rdc(FSCR_OFS_STAT, 32'h0, FSCR_RESP_OK);
      rdc(FSCR_OFS_IRQS, 32'h3f, FSCR_RESP_OK);
      wrc(FSCR_OFS_IRQM, 32'h0, FSCR_RESP_OK);
      chk({31'h0, irq}, 32'h0);
      wrc(FSCR_OFS_IRQM, 32'h7f, FSCR_RESP_OK);
      wrc(FSCR_OFS_IRQS, 32'h3f, FSCR_RESP_OK);
      chk({31'h0, irq}, 32'h0);
      $display("exceptions done");
   endtask

   task automatic t_lazy();
      ev(3'h0, 32'h2000_0017);
      chk({31'h0, lsp}, 32'h1);
      chk(frame, 32'h2000_0010);
      rdc(FSCR_OFS_CTX, 32'h8000_0001, FSCR_RESP_OK);
      rdc(FSCR_OFS_FRAME, 32'h2000_0010, FSCR_RESP_OK);
      chk({31'h0, irq}, 32'h1);
      ev(3'h1, 32'h0);
      chk({31'h0, lsp}, 32'h0);
      wrc(FSCR_OFS_IRQS, 32'h40, FSCR_RESP_OK);
      wrc(FSCR_OFS_CTX, 32'h0, FSCR_RESP_OK);
      chk({31'h0, lse}, 32'h0);
      ev(3'h0, 32'h3000_0000);
      chk({31'h0, lsp}, 32'h0);
      chk(frame, 32'h2000_0010);
      chk({31'h0, irq}, 32'h0);
      wrc(FSCR_OFS_CTX, 32'h8000_0000, FSCR_RESP_OK);
      $display("lazy frame done");
   endtask

   task automatic t_access();
      wrc(FSCR_OFS_FRAME, 32'hffff_ffff, FSCR_RESP_OK);
      rdc(FSCR_OFS_FRAME, 32'hffff_fff8, FSCR_RESP_OK);
      wstrb <= 4'h1;
      wrc(FSCR_OFS_FRAME, 32'h0, FSCR_RESP_OK);
      rdc(FSCR_OFS_FRAME, 32'hffff_ff00, FSCR_RESP_OK);
      wstrb <= 4'hf;
      wrc(8'h20, 32'hffff_ffff, FSCR_RESP_ERR);
      rdc(8'h20, 32'h0, FSCR_RESP_ERR);
      $display("access kinds done");
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      clk = 1'b0;
      reset = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, granted, go} = 7'h0;
      awaddr = 32'h0;
      wdata = 32'h0;
      wstrb = 4'hf;
      araddr = 32'h0;
      arg = 32'h0;
      op = 3'h0;
      error_cnt = 0;
      n_tests = 0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      granted <= 1'b1;
      t_reset();
      t_modes();
      t_cmp();
      t_exc();
      t_lazy();
      t_access();
      end_sim();
   end
endmodule
